/* File: single_wire_block_commands_tb.sv */
`timescale 1ns/1ps
// ****************
// testbench
// ****************
module single_wire_block_commands_tb import swb_pkg::*; ;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cmd_valid = 1'b0;
   swb_cmd_type cmd = '0;
   logic        wr_valid = 1'b0;
   logic [7:0]  wr_data = 8'h00;
   logic        cfg_speed = 1'b0;
   logic        cfg_spu_clear = 1'b0;
   logic        ack = 1'b0;
   logic        sel = 1'b1;
   logic        rd_ready = 1'b0;
   logic        cfg_spu_arm = 1'b0;
   logic        present = 1'b0;
   logic        shorted = 1'b0;
   logic [7:0]  pattern = 8'hFF;
   logic        cmd_ready, wr_ready, rd_valid, done, bus_out, bus_oe_n;
   logic        spu_on, gpio_out, gpio_oe_n, slv_low, line;
   logic [7:0]  rd_data, result, status, b;
   logic [15:0] crc;
   logic [7:0]  rxq[$];
   int          n_mismatch = 0;
   int          checks_done = 0;
   always #2 clk = ~clk;
   // read side stalls every other cycle
   always @(posedge clk) rd_ready <= !rd_ready;
   // short bus timings keep the run brief, same ordering within a slot and within the reset release as the defaults
   localparam int unsigned T_RSTL = 40;
   localparam int unsigned SHORT_SAMPLE_TIME  = 4;
   localparam int unsigned PRESENCE_SAMPLE_TIME  = 8;
   localparam int unsigned T_RSTH = 14;
   localparam int unsigned T_W0L  = 10;
   localparam int unsigned T_W1L  = 2;
   localparam int unsigned T_MSR  = 6;
   localparam int unsigned T_SLOT = 14;
   localparam int unsigned T_HOLD = 50;
   // pulled-up line, low when either side pulls
   assign line = (bus_oe_n | bus_out) & ~slv_low;
   swb_top #(.P_RSTL(T_RSTL), .P_MSI(SHORT_SAMPLE_TIME), .P_MSP(PRESENCE_SAMPLE_TIME),
      .P_RSTH(T_RSTH), .P_W0L(T_W0L), .P_W1L(T_W1L), .P_MSR(T_MSR),
      .P_SLOT(T_SLOT), .P_HOLD(T_HOLD)) u_swb_top (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_ready(rd_ready), .done(done), .result(result),
      .cfg_speed(cfg_speed), .cfg_spu_arm(cfg_spu_arm),
      .cfg_spu_clear(cfg_spu_clear), .stat_read_ack(ack),
      .stat_ptr_sel(sel), .status(status), .bus_in(line),
      .bus_out(bus_out), .bus_oe_n(bus_oe_n), .spu_on(spu_on),
      .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
   swb_slave u_swb_slave (.clk(clk), .mst_low(!bus_oe_n),
      .slv_low(slv_low), .present(present), .shorted(shorted),
      .pattern(pattern));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic push(input logic [7:0] d);
      wr_valid <= 1'b1;
      wr_data  <= d;
      @(posedge clk);
      for (int i = 0; i < 100 && !wr_ready; i++)
         @(posedge clk);
      if (!wr_ready) begin
         n_mismatch++;
         summarize();
      end
   endtask
   // one command, read bytes collected until done, result compared
   task automatic run(input logic [7:0] op, prm, ln, exp);
      rxq.delete();
      wr_valid  <= 1'b0;
      cmd_valid <= 1'b1;
      cmd       <= '{op, prm, ln};
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (int i = 0; i < 30000 && !done; i++) begin
         @(posedge clk);
         if (rd_valid && rd_ready)
            rxq.push_back(rd_data);
      end
      if (!done) begin
         n_mismatch++;
         summarize();
      end
      chk(16'(result), 16'(exp));
      $display("command %h finished", op);
   endtask
   task automatic stat(input logic [7:0] exp);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk(16'(status), 16'(exp));
   endtask
   initial begin
      repeat (6) @(posedge clk);
      chk(16'({cmd_ready, bus_oe_n, gpio_oe_n, spu_on, status}), 16'hE00);
      rst <= 1'b0;
      @(posedge clk);
      run(8'h00, 8'h00, 8'h00, 8'h55);
      push(8'hA5);
      run(8'h68, 8'h01, 8'h01, 8'h33);
      run(8'h68, 8'h03, 8'h01, 8'hAA);
      stat(8'h09);
      present <= 1'b1;
      pattern <= 8'h3C;
      push(8'hA5);
      push(8'hFF);
      run(8'hAB, 8'h0D, 8'h02, 8'hAA);
      chk(16'({rxq[0], rxq[1]}), 16'h243C);
      chk(16'({spu_on, gpio_oe_n, gpio_out}), 16'h4);
      stat(8'h0A);
      cfg_spu_clear <= 1'b1;
      @(posedge clk);
      cfg_spu_clear <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk(16'({spu_on, gpio_oe_n}), 16'h1);
      push(8'hA5);
      run(8'h68, 8'h00, 8'h01, 8'h22);
      pattern <= 8'h5A;
      run(8'h50, 8'h03, 8'h00, 8'hAA);
      chk(16'(rxq.size()), 16'h3);
      chk({rxq[0], rxq[2]}, 16'h5A5A);
      shorted <= 1'b1;
      push(8'h00);
      run(8'h68, 8'h01, 8'h01, 8'h33);
      sel <= 1'b0;
      stat(8'h0C);
      sel <= 1'b1;
      stat(8'h04);
      shorted <= 1'b0;
      run(8'h68, 8'h01, 8'h01, 8'hAA);
      stat(8'h0A);
      cfg_speed <= 1'b1;
      stat(8'h1A);
      cfg_speed <= 1'b0;
      // alternating answers look like one device with rom bytes 55h
      pattern <= 8'h55;
      run(8'h11, 8'h05, 8'h00, 8'hAA);
      chk(16'(rxq.size()), 16'h9);
      chk({rxq[0], rxq[8]}, 16'h5501);
      cfg_spu_arm <= 1'b1;
      push(8'h00);
      run(8'h68, 8'h00, 8'h01, 8'hAA);
      chk(16'(spu_on), 16'h1);
      cfg_spu_arm <= 1'b0;
      // eight bytes fill the buffer, then feed the crc
      crc = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         b = 8'h10 + 8'(i);
         push(b);
         for (int k = 0; k < 8; k++)
            crc = (crc[0] ^ b[k]) ? (crc >> 1) ^ 16'hA001 : crc >> 1;
      end
      wr_valid <= 1'b0;
      @(posedge clk);
      chk(16'(wr_ready), 16'h0);
      run(8'hCC, 8'h00, 8'h08, 8'hAA);
      chk({rxq[1], rxq[0]}, ~crc);
      summarize();
   end
endmodule // single_wire_block_commands_tb

/* File: swb_cfg.svh */
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH
`define SWB_CLK_NS 4
`define SWB_CYC(t) (((t) + `SWB_CLK_NS - 1) / `SWB_CLK_NS)
`define SWB_T_RSTL_NS 480000
`define SWB_SHORT_SAMPLE_TIME_NS 8000
`define SWB_PRESENCE_SAMPLE_TIME_NS 68000
`define SWB_T_RSTH_NS 480000
`define SWB_T_W0L_NS 60000
`define SWB_T_W1L_NS 6000
`define SWB_T_MSR_NS 15000
`define SWB_T_SLOT_NS 70000
`define SWB_T_HOLD_NS 2000000
`define SWB_OD_DIV 8
`define SWB_OP_BLOCK 8'hAB
`define SWB_OP_WRITE 8'h68
`define SWB_OP_READ 8'h50
`define SWB_OP_SEARCH 8'h11
`define SWB_OP_FCS 8'h57
`define SWB_OP_CRC 8'hCC
`define SWB_P_RST 0
`define SWB_P_IGN 1
`define SWB_P_SPU 2
`define SWB_P_PE 3
`define SWB_P_SRST 2
`define SWB_ST_SPD 4
`define SWB_ST_LL 3
`define SWB_ST_SD 2
`define SWB_ST_PPD 1
`define SWB_ST_IGN 0
`define SWB_CRC_POLY 16'hA001
`define SWB_CRC_RES 16'hB001
`define SWB_RELEASE 8'hAA
`define SWB_R_OK 8'hAA
`define SWB_R_NOPRES 8'h33
`define SWB_R_MISMATCH 8'h22
`define SWB_R_CRCERR 8'hA2
`define SWB_R_NODEV 8'h44
`define SWB_R_BADOP 8'h55
`define SWB_FIFO_DEPTH 8
`endif

/* File: swb_pkg.sv */
`include "swb_cfg.svh"
package swb_pkg;
   typedef enum logic [2:0] {S_IDLE, S_NEXT, S_RST_LOW, S_RST_REL,
      S_SLOT_LOW, S_SLOT_REL, S_HOLD} swb_st_type;
   typedef enum logic [2:0] {PH_DATA, PH_CRC, PH_REL, PH_RES, PH_SRCH,
      PH_EMIT} swb_ph_type;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] param;
      logic [7:0] len;
   } swb_cmd_type;
   typedef struct packed {
      swb_st_type  st;
      swb_ph_type  ph;
      swb_cmd_type cmd;
      logic [31:0] cnt;
      logic [7:0]  left;
      logic [2:0]  bi;
      logic        bd;
      logic [7:0]  tx;
      logic [7:0]  tx0;
      logic [7:0]  rx;
      logic        wb;
      logic        rb;
      logic [1:0]  trip;
      logic        idb;
      logic [15:0] crc;
      logic        err;
      logic [6:0]  pos;
      logic [6:0]  disc;
      logic [6:0]  ld;
      logic [63:0] rom;
      logic [71:0] eb;
      logic        ll;
      logic        sd;
      logic        presence_seen;
      logic        ign;
      logic        spd;
      logic        strong_pullup;
      logic        keep;
      logic        g_n;
      logic        oe_n;
      logic        ov;
      logic [7:0]  od;
      logic        done;
      logic [7:0]  res;
      logic        rdy;
   } swb_regs_type;
   function automatic logic [15:0] swb_crc_byte(input logic [15:0] c,
                                                input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ `SWB_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

/* File: swb_slave.sv */
`timescale 1ns/1ps
// ****************
// bus slave model
// ****************
module swb_slave (
   // clock
   input  wire logic       clk,
   // line
   input  wire logic       mst_low,
   output logic            slv_low,
   // behaviour
   input  wire logic       present,
   input  wire logic       shorted,
   input  wire logic [7:0] pattern
);
   int         lowc = 0;
   int         relc = 99;
   int         slc  = 99;
   logic [2:0] bi   = 3'h0;
   logic       cur  = 1'b1;
   logic       rel;
   logic       slot;
   // a long low is a reset, a fresh short low starts a slot
   assign rel  = !mst_low && lowc > 20;
   assign slot = mst_low && lowc == 0;
   always @(posedge clk) begin
      lowc <= mst_low ? lowc + 1 : 0;
      relc <= rel ? 0 : (relc < 99 ? relc + 1 : relc);
      slc  <= slot ? 0 : (slc < 99 ? slc + 1 : slc);
      if (rel)
         bi <= 3'h0;
      else if (slot) begin
         cur <= pattern[bi];
         bi  <= bi + 3'h1;
      end
   end
   // zero bits stretch the slot low past the master's sample point
   assign slv_low = shorted || (present && relc >= 3 && relc <= 10)
                    || (slc < 6 && !cur);
endmodule // swb_slave

/* File: swb_top.sv */
// Contract
// - line level sampled on status read
// - reset sets short flag on low
// - later reset clears short when gone
// - reset sets presence when pulse seen
// - no pulse or short clears presence
// - status echoes last ignore setting
// - optional leading reset, stop without presence
// - ignore bit continues regardless of presence
// - strong pullup at block end, held
// - gpio conducts after successful block
// - write block verifies readback, flags error
// - read block reads count bytes
// - search returns one rom code
// - search reset restarts at first device
// - last device flag follows rom code
// - full sequence checks both slave crcs
// - pullup held delay times 2ms
// - crc16 over host supplied bytes
// - config arms pullup after byte transfers
// - config selects standard or overdrive
`timescale 1ns/1ps
`include "swb_cfg.svh"

// ****************************************
// data fifo
// ****************************************
module swb_fifo #(
   parameter int W = 8,
   parameter int D = `SWB_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   // depth must be a power of two for the wrap bit
   localparam int A = $clog2(D);
   logic [W-1:0] mem [D];
   logic [A:0]   wp_q;
   logic [A:0]   wp_d;
   logic [A:0]   rp_q;
   logic [A:0]   rp_d;
   logic         full;
   logic         empty;

   assign full = (wp_q[A] != rp_q[A]) && (wp_q[A-1:0] == rp_q[A-1:0]);
   assign empty = (wp_q == rp_q);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_q[A-1:0]];

   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      if (in_valid && !full) wp_d = wp_q + 1'b1;
      if (out_ready && !empty) rp_d = rp_q + 1'b1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   always_ff @(posedge clk) begin
      if (in_valid && !full) mem[wp_q[A-1:0]] <= in_data;
   end
endmodule // swb_fifo

// ****************************************
// command engine
// ****************************************
module swb_top import swb_pkg::*; #(
   parameter int unsigned P_RSTL = `SWB_CYC(`SWB_T_RSTL_NS),
   parameter int unsigned P_MSI  = `SWB_CYC(`SWB_SHORT_SAMPLE_TIME_NS),
   parameter int unsigned P_MSP  = `SWB_CYC(`SWB_PRESENCE_SAMPLE_TIME_NS),
   parameter int unsigned P_RSTH = `SWB_CYC(`SWB_T_RSTH_NS),
   parameter int unsigned P_W0L  = `SWB_CYC(`SWB_T_W0L_NS),
   parameter int unsigned P_W1L  = `SWB_CYC(`SWB_T_W1L_NS),
   parameter int unsigned P_MSR  = `SWB_CYC(`SWB_T_MSR_NS),
   parameter int unsigned P_SLOT = `SWB_CYC(`SWB_T_SLOT_NS),
   parameter int unsigned P_HOLD = `SWB_CYC(`SWB_T_HOLD_NS)
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // command
   input  wire logic         cmd_valid,
   input  wire swb_cmd_type  cmd,
   output logic              cmd_ready,
   // write data
   input  wire logic         wr_valid,
   input  wire logic [7:0]   wr_data,
   output logic              wr_ready,
   // read data
   output logic              rd_valid,
   output logic [7:0]        rd_data,
   input  wire logic         rd_ready,
   // completion
   output logic              done,
   output logic [7:0]        result,
   // master configuration
   input  wire logic         cfg_speed,
   input  wire logic         cfg_spu_arm,
   input  wire logic         cfg_spu_clear,
   // status read
   input  wire logic         stat_read_ack,
   input  wire logic         stat_ptr_sel,
   output logic [7:0]        status,
   // bus pin
   input  wire logic         bus_in,
   output logic              bus_out,
   output logic              bus_oe_n,
   // power pins
   output logic              spu_on,
   output logic              gpio_out,
   output logic              gpio_oe_n
);
   function automatic int unsigned od(input int unsigned v);
      return (v / `SWB_OD_DIV == 0) ? 1 : v / `SWB_OD_DIV;
   endfunction

   swb_regs_type q;
   swb_regs_type d;
   logic         b1_q;
   logic         bs;
   logic         pop;
   logic         fv;
   logic [7:0]   fd;
   logic [31:0]  t_rstl, short_sample_time, presence_sample_time, t_rsth;
   logic [31:0]  t_w0l, t_w1l, t_msr, t_slot;

   swb_fifo #(.W(8), .D(`SWB_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (wr_valid),
      .in_data   (wr_data),
      .in_ready  (wr_ready),
      .out_valid (fv),
      .out_data  (fd),
      .out_ready (pop)
   );

   // pin is asynchronous to clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         b1_q <= 1'b1;
         bs   <= 1'b1;
      end else begin
         b1_q <= bus_in;
         bs   <= b1_q;
      end
   end

   always_comb begin
      t_rstl = q.spd ? 32'(od(P_RSTL)) : 32'(P_RSTL);
      short_sample_time  = q.spd ? 32'(od(P_MSI))  : 32'(P_MSI);
      presence_sample_time  = q.spd ? 32'(od(P_MSP))  : 32'(P_MSP);
      t_rsth = q.spd ? 32'(od(P_RSTH)) : 32'(P_RSTH);
      t_w0l  = q.spd ? 32'(od(P_W0L))  : 32'(P_W0L);
      t_w1l  = q.spd ? 32'(od(P_W1L))  : 32'(P_W1L);
      t_msr  = q.spd ? 32'(od(P_MSR))  : 32'(P_MSR);
      t_slot = q.spd ? 32'(od(P_SLOT)) : 32'(P_SLOT);
   end

   always_comb begin
      logic       go;
      logic       fin;
      logic [7:0] code;
      logic       dir;
      go = 1'b0;
      fin = 1'b0;
      code = `SWB_R_OK;
      dir = 1'b0;
      d = q;
      pop = 1'b0;
      d.done = 1'b0;
      d.spd = cfg_speed;
      if (q.ov && rd_ready) d.ov = 1'b0;
      if (stat_read_ack && stat_ptr_sel) d.ll = bs;
      if (cfg_spu_clear) begin
         d.strong_pullup = 1'b0;
         d.keep = 1'b0;
         d.g_n = 1'b1;
      end
      unique case (q.st)
         S_IDLE: if (cmd_valid) begin
            d.cmd = cmd;
            d.rdy = 1'b0;
            d.err = 1'b0;
            d.crc = 16'h0000;
            d.left = cmd.len;
            d.pos = 7'h00;
            d.disc = 7'h00;
            d.trip = 2'h0;
            d.bd = 1'b0;
            d.cnt = 32'h0;
            d.ph = (cmd.op == `SWB_OP_SEARCH) ? PH_SRCH : PH_DATA;
            d.st = S_NEXT;
            if (cmd.op == `SWB_OP_READ) d.left = cmd.param;
            if (cmd.op == `SWB_OP_SEARCH && cmd.param[`SWB_P_SRST])
               d.ld = 7'h00;
            if (cmd.op == `SWB_OP_FCS ||
                ((cmd.op == `SWB_OP_BLOCK || cmd.op == `SWB_OP_WRITE ||
                  cmd.op == `SWB_OP_SEARCH) && cmd.param[`SWB_P_RST])) begin
               d.ign = (cmd.op == `SWB_OP_FCS) ? 1'b0
                       : cmd.param[`SWB_P_IGN];
               d.st = S_RST_LOW;
               d.oe_n = 1'b0;
               if (!q.keep) d.strong_pullup = 1'b0;
            end
            if (!(cmd.op inside {`SWB_OP_BLOCK, `SWB_OP_WRITE, `SWB_OP_READ,
                  `SWB_OP_SEARCH, `SWB_OP_FCS, `SWB_OP_CRC})) begin
               fin = 1'b1;
               code = `SWB_R_BADOP;
            end
         end
         S_RST_LOW: begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == t_rstl - 32'h1) begin
               d.cnt = 32'h0;
               d.oe_n = 1'b1;
               d.st = S_RST_REL;
            end
         end
         S_RST_REL: begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == short_sample_time - 32'h1) begin
               d.sd = !bs;
               if (!bs) d.presence_seen = 1'b0;
            end
            if (q.cnt == presence_sample_time - 32'h1) d.presence_seen = !bs && !q.sd;
            if (q.cnt == t_rsth - 32'h1) begin
               d.st = S_NEXT;
               if (!q.presence_seen && !q.ign) begin
                  fin = 1'b1;
                  code = `SWB_R_NOPRES;
               end
            end
         end
         S_SLOT_LOW: begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == t_msr - 32'h1) d.rb = bs;
            if (q.cnt == (q.wb ? t_w1l : t_w0l) - 32'h1) begin
               d.oe_n = 1'b1;
               d.st = S_SLOT_REL;
            end
         end
         S_SLOT_REL: begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == t_msr - 32'h1) d.rb = bs;
            if (q.cnt == t_slot - 32'h1) begin
               unique case (q.trip)
                  2'h0: begin
                     d.rx = {q.rb, q.rx[7:1]};
                     d.tx = q.tx >> 1;
                     d.bi = q.bi + 3'h1;
                     if (q.bi == 3'h7) begin
                        d.st = S_NEXT;
                        d.bd = 1'b1;
                     end else go = 1'b1;
                  end
                  2'h1: begin
                     d.idb = q.rb;
                     d.trip = 2'h2;
                     d.wb = 1'b1;
                     go = 1'b1;
                  end
                  2'h2: begin
                     if (q.idb && q.rb) begin
                        fin = 1'b1;
                        code = `SWB_R_NODEV;
                     end else begin
                        if (q.idb != q.rb) dir = q.idb;
                        else if ((q.pos + 7'h01) < q.ld)
                           dir = q.rom[q.pos[5:0]];
                        else dir = ((q.pos + 7'h01) == q.ld);
                        if (q.idb == q.rb && !dir)
                           d.disc = q.pos + 7'h01;
                        d.rom[q.pos[5:0]] = dir;
                        d.wb = dir;
                        d.trip = 2'h3;
                        go = 1'b1;
                     end
                  end
                  2'h3: begin
                     d.pos = q.pos + 7'h01;
                     d.trip = 2'h0;
                     d.st = S_NEXT;
                  end
               endcase
            end
         end
         S_HOLD: begin
            d.cnt = q.cnt + 32'h1;
            if (q.left == 8'h00) begin
               if (!q.keep) d.strong_pullup = 1'b0;
               d.ph = PH_RES;
               d.left = 8'h03;
               d.crc = 16'h0000;
               d.st = S_NEXT;
            end else if (q.cnt == 32'(P_HOLD) - 32'h1) begin
               d.cnt = 32'h0;
               d.left = q.left - 8'h01;
            end
         end
         S_NEXT: unique case (q.ph)
            PH_DATA: if (q.bd) begin
               d.bd = 1'b0;
               if (q.cmd.op == `SWB_OP_WRITE && q.rx != q.tx0)
                  d.err = 1'b1;
               if (q.cmd.op == `SWB_OP_BLOCK ||
                   q.cmd.op == `SWB_OP_READ) begin
                  d.ov = 1'b1;
                  d.od = q.rx;
               end
               if (q.cmd.op == `SWB_OP_FCS)
                  d.crc = swb_crc_byte(q.crc, q.tx0);
               if (cfg_spu_arm) d.strong_pullup = 1'b1;
            end else if (q.left == 8'h00) begin
               if (q.cmd.op == `SWB_OP_CRC) begin
                  d.eb = {56'h0, ~q.crc};
                  d.left = 8'h02;
                  d.ph = PH_EMIT;
               end else if (q.cmd.op == `SWB_OP_FCS) begin
                  d.left = 8'h02;
                  d.ph = PH_CRC;
               end else begin
                  fin = 1'b1;
                  code = q.err ? `SWB_R_MISMATCH : `SWB_R_OK;
               end
            end else if (q.cmd.op == `SWB_OP_READ) begin
               if (!q.ov) begin
                  d.tx = 8'hFF;
                  d.tx0 = 8'hFF;
                  d.left = q.left - 8'h01;
                  go = 1'b1;
               end
            end else if (fv && !q.ov) begin
               pop = 1'b1;
               d.left = q.left - 8'h01;
               if (q.cmd.op == `SWB_OP_CRC)
                  d.crc = swb_crc_byte(q.crc, fd);
               else begin
                  d.tx = fd;
                  d.tx0 = fd;
                  go = 1'b1;
               end
            end
            PH_CRC: if (q.bd) begin
               d.bd = 1'b0;
               d.crc = swb_crc_byte(q.crc, q.rx);
            end else if (q.left == 8'h00) begin
               if (q.crc != `SWB_CRC_RES) begin
                  fin = 1'b1;
                  code = `SWB_R_CRCERR;
               end else begin
                  d.tx = `SWB_RELEASE;
                  d.ph = PH_REL;
                  go = 1'b1;
               end
            end else begin
               d.tx = 8'hFF;
               d.left = q.left - 8'h01;
               go = 1'b1;
            end
            PH_REL: begin
               d.bd = 1'b0;
               d.strong_pullup = 1'b1;
               d.cnt = 32'h0;
               d.left = q.cmd.param;
               d.st = S_HOLD;
            end
            PH_RES: if (q.bd) begin
               d.bd = 1'b0;
               d.crc = swb_crc_byte(q.crc, q.rx);
               if (q.left == 8'h02) begin
                  d.ov = 1'b1;
                  d.od = q.rx;
               end
            end else if (q.left == 8'h00) begin
               fin = 1'b1;
               code = (q.crc == `SWB_CRC_RES) ? `SWB_R_OK : `SWB_R_CRCERR;
            end else if (!q.ov) begin
               d.tx = 8'hFF;
               d.left = q.left - 8'h01;
               go = 1'b1;
            end
            PH_SRCH: if (q.pos == 7'h40) begin
               d.eb = {7'h00, q.disc == 7'h00, q.rom};
               d.left = 8'h09;
               d.ph = PH_EMIT;
            end else begin
               d.trip = 2'h1;
               d.wb = 1'b1;
               go = 1'b1;
            end
            PH_EMIT: if (!q.ov) begin
               if (q.left == 8'h00) fin = 1'b1;
               else begin
                  d.ov = 1'b1;
                  d.od = q.eb[7:0];
                  d.eb = q.eb >> 8;
                  d.left = q.left - 8'h01;
               end
            end
         endcase
      endcase
      if (go) begin
         d.st = S_SLOT_LOW;
         d.cnt = 32'h0;
         d.oe_n = 1'b0;
         if (d.trip == 2'h0) d.wb = d.tx[0];
         if (q.st == S_NEXT) d.bi = 3'h0;
         if (!q.keep) d.strong_pullup = 1'b0;
      end
      if (fin) begin
         d.st = S_IDLE;
         d.oe_n = 1'b1;
         d.rdy = 1'b1;
         d.done = 1'b1;
         d.res = code;
         if (code == `SWB_R_OK) begin
            if ((d.cmd.op == `SWB_OP_BLOCK || d.cmd.op == `SWB_OP_WRITE) &&
                d.cmd.param[`SWB_P_SPU]) begin
               d.strong_pullup = 1'b1;
               d.keep = 1'b1;
            end
            if (d.cmd.op == `SWB_OP_BLOCK && d.cmd.param[`SWB_P_PE]) begin
               d.strong_pullup = 1'b1;
               d.keep = 1'b1;
               d.g_n = 1'b0;
            end
            if (d.cmd.op == `SWB_OP_SEARCH) d.ld = q.disc;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.oe_n <= 1'b1;
         q.g_n <= 1'b1;
         q.rdy <= 1'b1;
      end else q <= d;
   end

   assign cmd_ready = q.rdy;
   assign rd_valid = q.ov;
   assign rd_data = q.od;
   assign done = q.done;
   assign result = q.res;
   assign status = {3'h0, q.spd, q.ll, q.sd, q.presence_seen, q.ign};
   assign bus_out = 1'b0;
   assign bus_oe_n = q.oe_n;
   assign spu_on = q.strong_pullup;
   assign gpio_out = 1'b0;
   assign gpio_oe_n = q.g_n;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence rst_end;
      q.st == S_RST_REL && q.cnt == t_rsth - 32'h1;
   endsequence
   ll_sample_a: assert property (stat_read_ack && stat_ptr_sel
      |=> status[`SWB_ST_LL] == $past(bs)) else $error("line level");
   short_set_a: assert property (q.st == S_RST_REL &&
      q.cnt == short_sample_time - 32'h1 && !bs |=> q.sd && !q.presence_seen)
      else $error("short not set");
   short_clr_a: assert property (q.st == S_RST_REL &&
      q.cnt == short_sample_time - 32'h1 && bs |=> !q.sd) else $error("short stuck");
   pres_set_a: assert property (q.st == S_RST_REL &&
      q.cnt == presence_sample_time - 32'h1 && !bs && !q.sd |=> q.presence_seen)
      else $error("presence missed");
   pres_short_a: assert property (q.sd |-> !q.presence_seen)
      else $error("presence with short");
   ign_echo_a: assert property (cmd_valid && cmd_ready &&
      cmd.op == `SWB_OP_BLOCK && cmd.param[`SWB_P_RST]
      |=> status[`SWB_ST_IGN] == $past(cmd.param[`SWB_P_IGN]))
      else $error("ignore echo");
   stop_a: assert property (rst_end ##0 (!q.presence_seen && !q.ign)
      |=> done && result == `SWB_R_NOPRES) else $error("no stop");
   go_on_a: assert property (rst_end ##0 q.ign
      |=> q.st == S_NEXT) else $error("no continue");
   spu_keep_a: assert property (spu_on && q.keep && !cfg_spu_clear
      |=> spu_on) else $error("pullup dropped");
   pfet_spu_a: assert property (!gpio_oe_n |-> spu_on)
      else $error("gpio without pullup");
   wr_err_a: assert property (q.st == S_NEXT && q.ph == PH_DATA &&
      q.bd && q.cmd.op == `SWB_OP_WRITE && q.rx != q.tx0 |=> q.err)
      else $error("readback error lost");
   hold_spu_a: assert property (q.st == S_HOLD |-> spu_on)
      else $error("pullup off in hold");
endmodule // swb_top
